/* logic/aoc_pkg.sv */
// Package with the register map, field positions and reset values of the card window.
package aoc_pkg;

   localparam logic [9:0] AOC_BASE_MIN = 10'h100;
   localparam logic [9:0] AOC_BASE_MAX = 10'h3e0;
   localparam int AOC_WIN_BITS = 5;

   localparam logic [4:0] AOC_OFS_MODE = 5'h01;
   localparam logic [4:0] AOC_OFS_DAC0_LO = 5'h04;
   localparam logic [4:0] AOC_OFS_DAC0_HI = 5'h05;
   localparam logic [4:0] AOC_OFS_DAC1_LO = 5'h06;
   localparam logic [4:0] AOC_OFS_DAC1_HI = 5'h07;
   localparam logic [4:0] AOC_OFS_RANGE = 5'h0e;
   localparam logic [4:0] AOC_OFS_PORT_A = 5'h10;
   localparam logic [4:0] AOC_OFS_PORT_B = 5'h11;
   localparam logic [4:0] AOC_OFS_PORT_CTL = 5'h13;
   localparam logic [4:0] AOC_OFS_CAL_DRV = 5'h1c;
   localparam logic [4:0] AOC_OFS_CAL_RD = 5'h1d;

   localparam int AOC_BIT_CH1_TWOS = 5;
   localparam int AOC_BIT_CH0_TWOS = 4;
   localparam int AOC_BIT_CH1_RANGE = 3;
   localparam int AOC_BIT_CH0_RANGE = 2;
   localparam int AOC_BIT_CAL_SEL = 7;
   localparam int AOC_BIT_CAL_SI = 6;
   localparam int AOC_BIT_CAL_SCK = 5;
   localparam int AOC_BIT_CAL_WP = 2;

   localparam logic [7:0] AOC_RST_MODE = 8'h00;
   localparam logic [7:0] AOC_RST_RANGE = 8'h0c;
   localparam logic [7:0] AOC_RST_CAL_DRV = 8'h00;
   localparam logic [7:0] AOC_RST_BYTE = 8'h00;
   localparam logic [9:0] AOC_RST_BASE = 10'h100;

   typedef struct packed {
      logic [11:0] code;
      logic twos_complement;
      logic unipolar;
   } aoc_dac_s;

   typedef struct packed {
      logic select;
      logic serial_in;
      logic serial_clock;
      logic write_protect;
   } aoc_cal_s;

endpackage : aoc_pkg

/* logic/aoc_dac_channel.sv */
// One converter channel: byte assembly of the 12-bit code and its mode bits.
`timescale 1ns/1ps
module aoc_dac_channel
   import aoc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [7:0] wdata,
   input wire logic twos_sel,
   input wire logic range_sel,
   output aoc_dac_s dac
);

   logic [11:0] code_r;
   logic twos_r;
   logic unipolar_r;

   // Each byte lands straight in the code; the converter sees the low byte at once.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         code_r <= 12'h000;
      end
      else
      begin
         if (wr_lo)
         begin
            code_r[7:0] <= wdata;
         end
         if (wr_hi)
         begin
            code_r[11:8] <= wdata[3:0];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         twos_r <= 1'b0;
         unipolar_r <= 1'b1;
      end
      else
      begin
         twos_r <= twos_sel;
         unipolar_r <= range_sel;
      end
   end

   // Each field has one writer; the struct is only put together here.
   assign dac = {code_r, twos_r, unipolar_r};

endmodule : aoc_dac_channel

/* logic/aoc_register_decode.sv */
// Host I/O window decode and register bank of the two-channel analog output card.
`timescale 1ns/1ps
module aoc_register_decode
   import aoc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic base_wr,
   input wire logic [9:0] base_addr,
   input wire logic [9:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe,
   output logic [9:0] base_addr_r,
   output logic base_valid_r,
   output aoc_dac_s dac0,
   output aoc_dac_s dac1,
   output aoc_cal_s cal_mem,
   input wire logic cal_mem_serial_out,
   output logic ppi_wr,
   output logic ppi_rd,
   output logic [1:0] ppi_addr,
   output logic [7:0] ppi_wdata,
   input wire logic [7:0] ppi_rdata
);

   logic [7:0] mode_r;
   logic [7:0] range_r;
   logic [7:0] cal_drv_r;
   logic [2:0] cal_so_sync_r;
   logic hit;
   logic [4:0] ofs;
   // Decoded single-cycle write strobes, one for each card register that the bus can write.
   logic wr_mode, wr_range, wr_cal, wr_d0l, wr_d0h, wr_d1l, wr_d1h;
   logic ppi_sel;
   logic rd_cal;
   logic rd_port;
   logic cal_so_r;

   // Software places the window; bases outside the legal span leave it closed.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         base_addr_r <= AOC_RST_BASE;
         base_valid_r <= 1'b0;
      end
      else if (base_wr)
      begin
         base_addr_r <= {base_addr[9:AOC_WIN_BITS], 5'h00};
         base_valid_r <= (base_addr >= AOC_BASE_MIN) && (base_addr <= AOC_BASE_MAX);
      end
   end

   // The low five address bits only pick a register, so every aligned base decodes alike.
   assign hit = base_valid_r && (io_addr[9:AOC_WIN_BITS] == base_addr_r[9:AOC_WIN_BITS]);
   assign ofs = io_addr[AOC_WIN_BITS-1:0];

   assign wr_mode = hit && io_wr && (ofs == AOC_OFS_MODE);
   assign wr_range = hit && io_wr && (ofs == AOC_OFS_RANGE);
   assign wr_cal = hit && io_wr && (ofs == AOC_OFS_CAL_DRV);
   assign wr_d0l = hit && io_wr && (ofs == AOC_OFS_DAC0_LO);
   assign wr_d0h = hit && io_wr && (ofs == AOC_OFS_DAC0_HI);
   assign wr_d1l = hit && io_wr && (ofs == AOC_OFS_DAC1_LO);
   assign wr_d1h = hit && io_wr && (ofs == AOC_OFS_DAC1_HI);
   assign ppi_sel = (ofs == AOC_OFS_PORT_A) || (ofs == AOC_OFS_PORT_B)
      || (ofs == AOC_OFS_PORT_CTL);

   // Write-only offsets have no read decode, so a read of them falls to the quiet branch.
   assign rd_cal = hit && io_rd && (ofs == AOC_OFS_CAL_RD);
   assign rd_port = hit && io_rd && ((ofs == AOC_OFS_PORT_A) || (ofs == AOC_OFS_PORT_B));

   // Command bytes are kept whole; the bits that software writes as zero are not used.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mode_r <= AOC_RST_MODE;
         range_r <= AOC_RST_RANGE;
         cal_drv_r <= AOC_RST_CAL_DRV;
      end
      else
      begin
         if (wr_mode)
         begin
            mode_r <= io_wdata;
         end
         if (wr_range)
         begin
            range_r <= io_wdata;
         end
         if (wr_cal)
         begin
            cal_drv_r <= io_wdata;
         end
      end
   end

   aoc_dac_channel u_dac0 (
      .clk(clk),
      .reset(reset),
      .wr_lo(wr_d0l),
      .wr_hi(wr_d0h),
      .wdata(io_wdata),
      .twos_sel(mode_r[AOC_BIT_CH0_TWOS]),
      .range_sel(range_r[AOC_BIT_CH0_RANGE]),
      .dac(dac0)
   );

   aoc_dac_channel u_dac1 (
      .clk(clk),
      .reset(reset),
      .wr_lo(wr_d1l),
      .wr_hi(wr_d1h),
      .wdata(io_wdata),
      .twos_sel(mode_r[AOC_BIT_CH1_TWOS]),
      .range_sel(range_r[AOC_BIT_CH1_RANGE]),
      .dac(dac1)
   );

   // The drive bits pass one more register so that the memory pins come from flip-flops.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cal_mem <= '0;
      end
      else
      begin
         cal_mem.select <= cal_drv_r[AOC_BIT_CAL_SEL];
         cal_mem.serial_in <= cal_drv_r[AOC_BIT_CAL_SI];
         cal_mem.serial_clock <= cal_drv_r[AOC_BIT_CAL_SCK];
         cal_mem.write_protect <= cal_drv_r[AOC_BIT_CAL_WP];
      end
   end

   // The memory's serial output is asynchronous to the bus clock.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cal_so_sync_r <= 3'b000;
      end
      else
      begin
         cal_so_sync_r <= {cal_so_sync_r[1:0], cal_mem_serial_out};
      end
   end

   // A new level counts only when the last two stages agree, so a one-cycle glitch is dropped.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cal_so_r <= 1'b0;
      end
      else if (cal_so_sync_r[2] == cal_so_sync_r[1])
      begin
         cal_so_r <= cal_so_sync_r[2];
      end
   end

   // Strobes to the parallel-port chip are registered, one cycle after the bus access.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ppi_wr <= 1'b0;
         ppi_rd <= 1'b0;
         ppi_addr <= 2'b00;
         ppi_wdata <= AOC_RST_BYTE;
      end
      else
      begin
         ppi_wr <= hit && io_wr && ppi_sel;
         // The control byte is write-only, so it never raises the read strobe.
         ppi_rd <= rd_port;
         ppi_addr <= ofs[1:0];
         ppi_wdata <= io_wdata;
      end
   end

   // Read data is registered; only the two readable groups ever drive the bus.
   // Port data is sampled in the access cycle, so the port chip must answer without a clock.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         io_rdata <= AOC_RST_BYTE;
         io_rdata_oe <= 1'b0;
      end
      else if (rd_cal)
      begin
         io_rdata <= {7'h00, cal_so_r};
         io_rdata_oe <= 1'b1;
      end
      else if (rd_port)
      begin
         io_rdata <= ppi_rdata;
         io_rdata_oe <= 1'b1;
      end
      else
      begin
         io_rdata <= AOC_RST_BYTE;
         io_rdata_oe <= 1'b0;
      end
   end

endmodule : aoc_register_decode

/* tb/aoc_register_decode_monitor.sv */
// Checker of the card window decode, watching the top module's ports.
`timescale 1ns/1ps
module aoc_register_decode_monitor
   import aoc_pkg::*;
(
   input logic clk,
   input logic reset,
   input logic [9:0] io_addr,
   input logic io_wr,
   input logic io_rd,
   input logic [7:0] io_wdata,
   input logic io_rdata_oe,
   input logic [9:0] base_addr_r,
   input logic base_valid_r,
   input aoc_dac_s dac0,
   input aoc_dac_s dac1,
   input aoc_cal_s cal_mem,
   input logic ppi_wr,
   input logic ppi_rd,
   input logic [1:0] ppi_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic hit;
   logic [4:0] ofs;
   assign ofs = io_addr[4:0];
   assign hit = base_valid_r && io_addr[9:5] == base_addr_r[9:5];

   base_range_a: assert property (base_valid_r |->
      base_addr_r >= AOC_BASE_MIN && base_addr_r <= AOC_BASE_MAX) else $error("base out of range");
   read_drive_a: assert property (io_rd && hit && ofs inside {5'h10, 5'h11, 5'h1d}
      |=> io_rdata_oe) else $error("readable offset not driven");
   read_quiet_a: assert property (io_rd && !(hit && ofs inside {5'h10, 5'h11, 5'h1d})
      |=> !io_rdata_oe) else $error("bus driven without a readable register");
   dac_low_a: assert property (io_wr && hit && ofs == AOC_OFS_DAC0_LO
      |=> dac0.code[7:0] == $past(io_wdata)) else $error("low byte not applied");
   coding_bits_a: assert property (io_wr && hit && ofs == AOC_OFS_MODE |-> ##2
      {dac1.twos_complement, dac0.twos_complement} == $past(io_wdata[5:4], 2))
      else $error("coding select wrong");
   range_bits_a: assert property (io_wr && hit && ofs == AOC_OFS_RANGE |-> ##2
      {dac1.unipolar, dac0.unipolar} == $past(io_wdata[3:2], 2)) else $error("range wrong");
   cal_drive_a: assert property (io_wr && hit && ofs == AOC_OFS_CAL_DRV |-> ##2
      cal_mem == {$past(io_wdata[7:5], 2), $past(io_wdata[2], 2)}) else $error("cal drive wrong");
   port_strobe_a: assert property (io_wr && hit && ofs inside {5'h10, 5'h11, 5'h13}
      |=> ppi_wr && ppi_addr == $past(io_addr[1:0])) else $error("port write lost");
   port_read_a: assert property (io_rd && hit && ofs inside {5'h10, 5'h11}
      |=> ppi_rd && ppi_addr == $past(io_addr[1:0])) else $error("port read strobe lost");
   port_quiet_a: assert property (!(io_rd && hit && ofs inside {5'h10, 5'h11})
      |=> !ppi_rd) else $error("stray port read strobe");
   hole_write_a: assert property (io_wr && !(hit && ofs inside {5'h04, 5'h05, 5'h06, 5'h07})
      |=> $stable(dac0.code) && $stable(dac1.code)) else $error("code changed by stray write");
   reset_state_a: assert property ($fell(reset) |-> dac0.unipolar && dac1.unipolar
      && !dac0.twos_complement && !dac1.twos_complement && cal_mem == 4'h0)
      else $error("reset state wrong");
endmodule : aoc_register_decode_monitor

bind aoc_register_decode aoc_register_decode_monitor u_aoc_register_decode_monitor (.clk,
   .reset, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_oe, .base_addr_r, .base_valid_r,
   .dac0, .dac1, .cal_mem, .ppi_wr, .ppi_rd, .ppi_addr);

/* tb/aoc_ppi_model.sv */
// Behavioural parallel-port chip: two data ports and a control byte.
`timescale 1ns/1ps
module aoc_ppi_model
(
   input wire logic clk,
   input wire logic wr,
   input wire logic [1:0] addr,
   input wire logic [1:0] rd_sel,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] regs_r [4];
   always_ff @(posedge clk)
   begin
      if (wr)
         regs_r[addr] <= wdata;
   end
   // Read data is selected by the host offset, since the card samples it in the access cycle.
   assign rdata = regs_r[rd_sel];
endmodule : aoc_ppi_model

/* tb/aoc_register_decode_tb.sv */
// Self-checking testbench of the card window decode.
`timescale 1ns/1ps
module aoc_register_decode_tb
   import aoc_pkg::*;
;
   logic clk, reset, base_wr, io_wr, io_rd, io_rdata_oe, base_valid_r, so, ppi_wr, ppi_rd;
   logic [9:0] base_addr, io_addr, base_addr_r;
   logic [7:0] io_wdata, io_rdata, ppi_wdata, ppi_rdata;
   logic [1:0] ppi_addr;
   logic [8:0] v;
   aoc_dac_s dac0, dac1;
   aoc_cal_s cal_mem;
   int n_errors = 0, checks = 0, cycles = 0;

   aoc_register_decode u_aoc_register_decode (.clk, .reset, .base_wr, .base_addr, .io_addr,
      .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rdata_oe, .base_addr_r, .base_valid_r, .dac0,
      .dac1, .cal_mem, .cal_mem_serial_out(so), .ppi_wr, .ppi_rd, .ppi_addr, .ppi_wdata,
      .ppi_rdata);
   aoc_ppi_model u_aoc_ppi_model (.clk, .wr(ppi_wr), .addr(ppi_addr), .rd_sel(io_addr[1:0]),
      .wdata(ppi_wdata), .rdata(ppi_rdata));

   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic setb(input logic [9:0] a);
      @(negedge clk);
      base_addr = a;
      base_wr = 1'b1;
      @(negedge clk);
      base_wr = 1'b0;
   endtask : setb

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [8:0] r);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      r = {io_rdata_oe, io_rdata};
   endtask : rd

   task automatic summarize();
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         n_errors++;
         summarize();
      end
   end

   initial
   begin
      {reset, base_wr, io_wr, io_rd, so, base_addr, io_addr, io_wdata} = {5'h10, 28'h0};
      repeat (12) @(negedge clk);
      reset = 1'b0;
      chk("reset", 12'h030, {dac0.twos_complement, dac1.twos_complement, dac1.unipolar,
         dac0.unipolar, cal_mem});
      setb(10'h0e0);
      chk("lowbase", 12'h0, base_valid_r);
      setb(10'h3e0);
      chk("topbase", 12'h1, base_valid_r);
      setb(10'h120);
      chk("base", 12'h120, base_addr_r);
      wr(10'h124, 8'ha5);
      wr(10'h125, 8'hf3);
      wr(10'h126, 8'h5c);
      wr(10'h127, 8'h0b);
      wr(10'h204, 8'hff);
      wr(10'h121, 8'h30);
      wr(10'h12e, 8'h08);
      wr(10'h13c, 8'ha4);
      wr(10'h12f, 8'hff);
      so = 1'b1;
      repeat (3) @(negedge clk);
      chk("code0", 12'h3a5, dac0.code);
      chk("code1", 12'hb5c, dac1.code);
      chk("mode", 12'h00e, {dac0.twos_complement, dac1.twos_complement, dac1.unipolar,
         dac0.unipolar});
      chk("caldrv", 12'h00b, cal_mem);
      wr(10'h130, 8'h5a);
      wr(10'h131, 8'hc3);
      wr(10'h133, 8'h80);
      rd(10'h13d, v);
      chk("calrd", 12'h101, v);
      rd(10'h130, v);
      chk("porta", 12'h15a, v);
      rd(10'h131, v);
      chk("portb", 12'h1c3, v);
      rd(10'h13c, v);
      chk("wonly", 12'h0, v);
      rd(10'h12f, v);
      chk("hole", 12'h0, v);
      rd(10'h230, v);
      chk("miss", 12'h0, v);
      so = 1'b0;
      repeat (4) @(negedge clk);
      rd(10'h13d, v);
      chk("calrd0", 12'h100, v);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      chk("rereset", 12'h030, {dac0.twos_complement, dac1.twos_complement, dac1.unipolar,
         dac0.unipolar, cal_mem});
      chk("reclosed", 12'h000, base_valid_r);
      summarize();
   end
endmodule : aoc_register_decode_tb
